// *** logic/ssp_status_pins.sv ***
/*
 * Serial port byte engine with its status flags, pin directions and a
 * transmit FIFO between the core write port and the shift register.
 * Assumes the core reaches the registers over a one-cycle read and write
 * strobe bus, and that the serial pins are asynchronous to clk_sys.
 */
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////

module ssp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign out_data = mem[rd_q[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_data;
	end
endmodule : ssp_fifo

////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// - Bit 7 shows transfer in progress.
// - Select asserted during master transfer flags error.
// - Error flag cleared only by writing zero.
// - Unread buffer at byte end flags overflow.
// - Overflow with overwrite enable replaces buffer.
// - Bit 3 shows receive buffer holds byte.
// - Empty transmit buffer at load sets underflow.
// - Transmit flag set empty, low when full.
// - Enabled interrupt follows transmit flag.
// - No new byte ends transfer, releases select.
// - Writing zero clears transmit flag.
// - Bit 0 shows full; zero write clears.
// - Data-in pin input master, output slave.
// - Data-out pin output master, input slave.
// - Eight-bit bytes, most significant bit first.
// - Master may send least significant first.
module ssp_status_pins
	import ssp_pkg::*;
#(
	parameter int HALF_PERIOD = SSP_HALF_PERIOD,
	parameter int FIFO_DEPTH = SSP_FIFO_DEPTH
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic master_mode,
	input wire logic ss_input_enable,
	input wire logic lsb_first_select,
	input wire logic overflow_overwrite_enable,
	input wire logic irq_enable,
	output logic irq,
	output logic tx_write_ready,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe,
	input wire logic ss_n_in,
	output logic ss_n_out,
	output logic ss_n_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe
);
	localparam int CW = $clog2(HALF_PERIOD + 1);
	localparam logic [CW-1:0] HALF_LAST = CW'(HALF_PERIOD - 1);

	ssp_state_t state_q;
	logic [SSP_SYNC_W-1:0] s1_q;
	logic [SSP_SYNC_W-1:0] s2_q;
	logic sclk_prev_q;
	logic [CW-1:0] div_q;
	logic sclk_q;
	logic [2:0] bit_q;
	logic [7:0] tx_sh_q;
	logic [7:0] rx_sh_q;
	logic [7:0] rx_buf_q;
	logic [7:0] rdata_q;
	logic multi_master_error_q;
	logic rxof_q;
	logic rxbf_q;
	logic txuf_q;
	logic txirq_q;
	logic txbf_q;
	logic irq_q;
	logic empty_prev_q;
	logic lsb_eff;
	logic ss_act;
	logic din;
	logic rise;
	logic fall;
	logic boundary;
	logic start_m;
	logic start_s;
	logic pop;
	logic rx_done;
	logic [7:0] rx_next;
	logic wr_st;
	logic wr_tx;
	logic rd_rx;
	logic f_valid;
	logic f_ready;
	logic [7:0] f_data;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = a == r;
	endfunction : hit

	assign wr_st = sfr_wr && hit(sfr_addr, SSP_ADDR_STATUS);
	assign wr_tx = sfr_wr && hit(sfr_addr, SSP_ADDR_TXBUF);
	assign rd_rx = sfr_rd && hit(sfr_addr, SSP_ADDR_RXBUF);

	////////////////////////////////////////////////////////////////////////////////

	// Bits are sclk, select, miso, mosi.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= SSP_SYNC_IDLE;
			s2_q <= SSP_SYNC_IDLE;
			sclk_prev_q <= 1'b0;
		end
		else
		begin
			s1_q <= {sclk_in, ss_n_in, miso_in, mosi_in};
			s2_q <= s1_q;
			sclk_prev_q <= s2_q[3];
		end
	end

	assign ss_act = !s2_q[2];
	assign lsb_eff = master_mode && lsb_first_select;
	assign din = master_mode ? s2_q[1] : s2_q[0];
	assign start_m = state_q == SSP_IDLE && master_mode && f_valid;
	assign start_s = state_q == SSP_IDLE && !master_mode && ss_act;

	always_comb
	begin
		rise = 1'b0;
		fall = 1'b0;
		if (state_q == SSP_MASTER)
		begin
			rise = div_q == HALF_LAST && !sclk_q;
			fall = div_q == HALF_LAST && sclk_q;
		end
		else if (state_q == SSP_SLAVE)
		begin
			rise = s2_q[3] && !sclk_prev_q;
			fall = !s2_q[3] && sclk_prev_q;
		end
	end

	assign boundary = fall && bit_q == SSP_FIRST_BIT;
	assign pop = (start_m || start_s || boundary) && f_valid;
	assign rx_done = rise && bit_q == SSP_LAST_BIT;
	assign rx_next = lsb_eff ? {din, rx_sh_q[7:1]} : {rx_sh_q[6:0], din};

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= SSP_IDLE;
		else
		begin
			case (state_q)
				SSP_IDLE:
				begin
					if (start_m)
						state_q <= SSP_MASTER;
					else if (start_s)
						state_q <= SSP_SLAVE;
				end
				SSP_MASTER:
				begin
					if (!master_mode || (boundary && !f_valid))
						state_q <= SSP_IDLE;
				end
				SSP_SLAVE:
				begin
					if (master_mode || !ss_act)
						state_q <= SSP_IDLE;
				end
				default:
					state_q <= SSP_IDLE;
			endcase
		end
	end

	// Serial clock generator, idle low, data sampled on the rising edge.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_q <= '0;
			sclk_q <= 1'b0;
		end
		else if (state_q != SSP_MASTER)
		begin
			div_q <= '0;
			sclk_q <= 1'b0;
		end
		else if (div_q == HALF_LAST)
		begin
			div_q <= '0;
			sclk_q <= !sclk_q;
		end
		else
			div_q <= div_q + 1'b1;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_q <= SSP_FIRST_BIT;
			tx_sh_q <= '0;
			rx_sh_q <= '0;
		end
		else
		begin
			if (start_m || start_s)
				bit_q <= SSP_FIRST_BIT;
			else if (rise)
				bit_q <= bit_q + 1'b1;
			if (rise)
				rx_sh_q <= rx_next;
			if (start_m || start_s || boundary)
				tx_sh_q <= f_valid ? f_data : '0;
			else if (fall)
				tx_sh_q <= lsb_eff ? {1'b0, tx_sh_q[7:1]} : {tx_sh_q[6:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_buf_q <= '0;
			rxbf_q <= 1'b0;
			rxof_q <= 1'b0;
		end
		else
		begin
			if (rx_done && (!rxbf_q || overflow_overwrite_enable))
				rx_buf_q <= rx_next;
			if (rx_done)
				rxbf_q <= 1'b1;
			else if (rd_rx)
				rxbf_q <= 1'b0;
			if (rx_done && rxbf_q && !rd_rx)
				rxof_q <= 1'b1;
			else if (rd_rx)
				rxof_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			multi_master_error_q <= 1'b0;
		else if (state_q == SSP_MASTER && ss_input_enable && ss_act)
			multi_master_error_q <= 1'b1;
		else if (wr_st && !sfr_wdata[SSP_BIT_MULTI_MASTER_ERROR])
			multi_master_error_q <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txuf_q <= 1'b0;
			txbf_q <= 1'b0;
			txirq_q <= 1'b0;
			empty_prev_q <= 1'b1;
			irq_q <= 1'b0;
		end
		else
		begin
			empty_prev_q <= !f_valid;
			if ((boundary || start_s) && !f_valid)
				txuf_q <= 1'b1;
			else if (wr_st && !sfr_wdata[SSP_BIT_TXUF])
				txuf_q <= 1'b0;
			if (!f_ready)
				txbf_q <= 1'b1;
			else if (wr_st && !sfr_wdata[SSP_BIT_TXBF])
				txbf_q <= 1'b0;
			if (!f_ready)
				txirq_q <= 1'b0;
			else if (!f_valid && !empty_prev_q)
				txirq_q <= 1'b1;
			else if (wr_tx || (wr_st && !sfr_wdata[SSP_BIT_TXIRQ]))
				txirq_q <= 1'b0;
			irq_q <= irq_enable && txirq_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= '0;
		else if (sfr_rd)
		begin
			if (hit(sfr_addr, SSP_ADDR_STATUS))
			begin
				rdata_q <= SSP_STATUS_RESET;
				rdata_q[SSP_BIT_BUSY] <= state_q != SSP_IDLE;
				rdata_q[SSP_BIT_MULTI_MASTER_ERROR] <= multi_master_error_q;
				rdata_q[SSP_BIT_RXOF] <= rxof_q;
				rdata_q[SSP_BIT_RXBF] <= rxbf_q;
				rdata_q[SSP_BIT_TXUF] <= txuf_q;
				rdata_q[SSP_BIT_TXIRQ] <= txirq_q;
				rdata_q[SSP_BIT_TXBF] <= txbf_q;
			end
			else if (hit(sfr_addr, SSP_ADDR_RXBUF))
				rdata_q <= rx_buf_q;
			else
				rdata_q <= '0;
		end
	end

	ssp_fifo #(
		.WIDTH(SSP_BYTE_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_txfifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(wr_tx),
		.in_ready(f_ready),
		.in_data(sfr_wdata),
		.out_valid(f_valid),
		.out_ready(pop),
		.out_data(f_data)
	);

	assign sfr_rdata = rdata_q;
	assign irq = irq_q;
	assign tx_write_ready = f_ready;
	assign sclk_out = sclk_q;
	assign sclk_oe = master_mode;
	assign ss_n_out = state_q != SSP_MASTER;
	assign ss_n_oe = master_mode && !ss_input_enable;
	assign mosi_out = lsb_eff ? tx_sh_q[0] : tx_sh_q[7];
	assign mosi_oe = master_mode;
	assign miso_out = tx_sh_q[7];
	assign miso_oe = !master_mode && state_q == SSP_SLAVE;
endmodule : ssp_status_pins

// *** logic/ssp_pkg.sv ***
/*
 * Constants shared by the serial port status logic: register addresses,
 * status bit positions, byte framing and engine states.
 * Assumes an 8-bit special function register bus on the core clock.
 */
package ssp_pkg;
	localparam logic [7:0] SSP_ADDR_STATUS = 8'hea;
	localparam logic [7:0] SSP_ADDR_TXBUF = 8'h9a;
	localparam logic [7:0] SSP_ADDR_RXBUF = 8'h9b;
	localparam int SSP_BIT_BUSY = 7;
	localparam int SSP_BIT_MULTI_MASTER_ERROR = 6;
	localparam int SSP_BIT_RXOF = 5;
	localparam int SSP_BIT_RXBF = 3;
	localparam int SSP_BIT_TXUF = 2;
	localparam int SSP_BIT_TXIRQ = 1;
	localparam int SSP_BIT_TXBF = 0;
	localparam logic [7:0] SSP_STATUS_RESET = 8'h00;
	localparam int SSP_BYTE_BITS = 8;
	localparam logic [2:0] SSP_LAST_BIT = 3'h7;
	localparam logic [2:0] SSP_FIRST_BIT = 3'h0;
	localparam int SSP_FIFO_DEPTH = 32;
	// Core clock cycles per half period of the generated serial clock.
	localparam int SSP_HALF_PERIOD = 4;
	localparam int SSP_SYNC_W = 4;
	// Idle pin levels in synchroniser order: clock low, select, miso and mosi high.
	localparam logic [SSP_SYNC_W-1:0] SSP_SYNC_IDLE = 4'h7;

	typedef enum logic [2:0]
	{
		SSP_IDLE = 3'b001,
		SSP_MASTER = 3'b010,
		SSP_SLAVE = 3'b100
	} ssp_state_t;
endpackage : ssp_pkg

// *** testbench/ssp_status_pins_assertions.sv ***
/* Checker for the serial port status block, bound to its top module.
   Assumes only the top module ports are visible. */
`timescale 1ns/10ps
module ssp_status_pins_assertions
	import ssp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic master_mode,
	input wire logic irq_enable,
	input wire logic irq,
	input wire logic tx_write_ready,
	input wire logic sclk_out,
	input wire logic ss_n_out,
	input wire logic miso_oe,
	input wire logic mosi_oe
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	logic stat_rd;
	logic sclk_q;
	logic [7:0] edges_q;
	assign stat_rd = sfr_rd && sfr_addr == SSP_ADDR_STATUS;
	// Counts serial clock rises within one select frame; the top bit marks that any rise was seen.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_q <= 1'b0;
			edges_q <= 8'h00;
		end
		else
		begin
			sclk_q <= sclk_out;
			if (ss_n_out)
				edges_q <= 8'h00;
			else if (sclk_out && !sclk_q)
				edges_q <= {1'b1, edges_q[6:0] + 7'h01};
		end
	end
	AST_MOSI_DIR: assert property (mosi_oe == master_mode) else $error("data out direction");
	AST_MISO_DIR: assert property (master_mode |-> !miso_oe) else $error("data in driven");
	AST_BUSY: assert property (stat_rd && master_mode && !ss_n_out ##1 !ss_n_out |-> sfr_rdata[7]) else $error("busy");
	AST_RSVD: assert property (stat_rd |=> !sfr_rdata[4]) else $error("bit 4 set");
	AST_IRQ: assert property (irq |-> $past(irq_enable)) else $error("irq not enabled");
	AST_TX_FULL: assert property (stat_rd && !tx_write_ready && !$past(tx_write_ready) |=> sfr_rdata[1:0] == 2'b01) else $error("full flags");
	AST_SCLK_IDLE: assert property (master_mode && ss_n_out |-> !sclk_out) else $error("clock outside frame");
	AST_BYTE_LEN: assert property ($rose(ss_n_out) |-> edges_q[2:0] == 3'h0 && edges_q != 8'h00) else $error("partial byte");
	cover property ($fell(ss_n_out));
	cover property (!tx_write_ready);
	cover property (irq);
	cover property (miso_oe);
endmodule : ssp_status_pins_assertions

bind ssp_status_pins ssp_status_pins_assertions u_ssp_status_pins_assertions (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.sfr_addr(sfr_addr),
	.sfr_rd(sfr_rd),
	.sfr_rdata(sfr_rdata),
	.master_mode(master_mode),
	.irq_enable(irq_enable),
	.irq(irq),
	.tx_write_ready(tx_write_ready),
	.sclk_out(sclk_out),
	.ss_n_out(ss_n_out),
	.miso_oe(miso_oe),
	.mosi_oe(mosi_oe)
);

// *** testbench/ssp_slave_model.sv ***
/* Behavioural serial slave on the far side of the pins.
   Assumes clock idle low, data sampled on its rising edge. */
`timescale 1ns/10ps
module ssp_slave_model
(
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] rx_byte
);
	logic [7:0] shift_q = 8'h00;
	logic [2:0] cnt_q = 3'h0;
	logic sclk_q = 1'b0;
	logic ss_q = 1'b1;
	logic miso_q = 1'b0;
	logic [7:0] rx_q = 8'h00;
	assign miso = miso_q;
	assign rx_byte = rx_q;
	// One process follows both lines so that every value has a single writer.
	always @(sclk or ss_n)
	begin
		if (ss_q && !ss_n)
		begin
			cnt_q = 3'h0;
			shift_q = tx_byte;
			miso_q = tx_byte[7];
		end
		else if (!ss_q && ss_n)
			miso_q = ~miso_q;
		else if (!ss_n && sclk && !sclk_q)
		begin
			rx_q = {rx_q[6:0], mosi};
			cnt_q = cnt_q + 3'h1;
		end
		else if (!ss_n && !sclk && sclk_q)
		begin
			shift_q = (cnt_q == 3'h0) ? tx_byte : {shift_q[6:0], 1'b0};
			miso_q = shift_q[7];
		end
		ss_q = ss_n;
		sclk_q = sclk;
	end
endmodule : ssp_slave_model

// *** testbench/ssp_status_pins_tb.sv ***
/* Self-checking bench for the serial port status block as a master and as a slave.
   Assumes the package, design, checker and slave model are compiled first. */
`timescale 1ns/10ps
module ssp_status_pins_tb
	import ssp_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0, sfr_rd = 1'b0, master_mode = 1'b1, ss_input_enable = 1'b0;
	logic lsb_first_select = 1'b0, overflow_overwrite_enable = 1'b0, irq_enable = 1'b1, tb_ss_n = 1'b1;
	logic tb_sclk = 1'b0, tb_mosi = 1'b0;
	logic [7:0] sbyte = 8'h3c, sgot = 8'h00;
	logic [7:0] ptx = 8'hc5;
	logic [7:0] sfr_rdata, prx;
	logic irq, tx_write_ready, sclk_out, sclk_oe, ss_n_out, ss_n_oe, miso_out, miso_oe, mosi_out, mosi_oe, pmiso;
	logic sclk_w, ss_w, miso_w, mosi_w;
	int err_total = 0;
	int comparisons = 0;
	always #50 clk_sys = ~clk_sys;
	assign sclk_w = sclk_oe ? sclk_out : tb_sclk;
	assign ss_w = ss_n_oe ? ss_n_out : tb_ss_n;
	assign miso_w = miso_oe ? miso_out : pmiso;
	assign mosi_w = mosi_oe ? mosi_out : tb_mosi;
	ssp_status_pins u_ssp_status_pins (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata),
		.master_mode(master_mode),
		.ss_input_enable(ss_input_enable),
		.lsb_first_select(lsb_first_select),
		.overflow_overwrite_enable(overflow_overwrite_enable),
		.irq_enable(irq_enable),
		.irq(irq),
		.tx_write_ready(tx_write_ready),
		.sclk_in(sclk_w),
		.sclk_out(sclk_out),
		.sclk_oe(sclk_oe),
		.ss_n_in(ss_w),
		.ss_n_out(ss_n_out),
		.ss_n_oe(ss_n_oe),
		.miso_in(miso_w),
		.miso_out(miso_out),
		.miso_oe(miso_oe),
		.mosi_in(mosi_w),
		.mosi_out(mosi_out),
		.mosi_oe(mosi_oe)
	);
	ssp_slave_model u_ssp_slave_model (.sclk(sclk_out), .ss_n(ss_n_out), .mosi(mosi_w), .tx_byte(ptx), .miso(pmiso),
		.rx_byte(prx));
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
		@(posedge clk_sys);
		chk(sfr_rdata, e);
	endtask : rd
	task automatic settle(input int n);
		repeat (4) @(posedge clk_sys);
		for (int i = 0; i < n && ss_n_out !== 1'b1; i++)
			@(posedge clk_sys);
		repeat (4) @(posedge clk_sys);
	endtask : settle
	task automatic xfer(input logic [7:0] d);
		wr(SSP_ADDR_TXBUF, d);
		settle(300);
	endtask : xfer
	initial
	begin
		#2000000;
		err_total++;
		complete_run();
	end
	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd(SSP_ADDR_STATUS, SSP_STATUS_RESET);
		rd(8'h55, 8'h00);
		wr(SSP_ADDR_TXBUF, 8'h3a);
		repeat (4) @(posedge clk_sys);
		rd(SSP_ADDR_STATUS, 8'h82);
		chk({7'h00, irq}, 8'h01);
		settle(300);
		chk({7'h00, ss_n_out}, 8'h01);
		chk(prx, 8'h3a);
		rd(SSP_ADDR_STATUS, 8'h0e);
		rd(SSP_ADDR_RXBUF, 8'hc5);
		rd(SSP_ADDR_STATUS, 8'h06);
		wr(SSP_ADDR_STATUS, 8'hff);
		rd(SSP_ADDR_STATUS, 8'h06);
		wr(SSP_ADDR_STATUS, 8'h00);
		rd(SSP_ADDR_STATUS, 8'h00);
		chk({7'h00, irq}, 8'h00);
		lsb_first_select <= 1'b1;
		xfer(8'h3a);
		chk(prx, 8'h5c);
		lsb_first_select <= 1'b0;
		ptx <= 8'h96;
		xfer(8'h11);
		rd(SSP_ADDR_STATUS, 8'h2e);
		rd(SSP_ADDR_RXBUF, 8'ha3);
		rd(SSP_ADDR_STATUS, 8'h06);
		overflow_overwrite_enable <= 1'b1;
		xfer(8'h22);
		ptx <= 8'h69;
		xfer(8'h33);
		rd(SSP_ADDR_RXBUF, 8'h69);
		ss_input_enable <= 1'b1;
		wr(SSP_ADDR_TXBUF, 8'h44);
		repeat (10) @(posedge clk_sys);
		tb_ss_n <= 1'b0;
		repeat (10) @(posedge clk_sys);
		tb_ss_n <= 1'b1;
		settle(300);
		rd(SSP_ADDR_RXBUF, 8'h69);
		rd(SSP_ADDR_STATUS, 8'h46);
		wr(SSP_ADDR_STATUS, 8'hbf);
		rd(SSP_ADDR_STATUS, 8'h06);
		ss_input_enable <= 1'b0;
		sfr_addr <= SSP_ADDR_TXBUF;
		sfr_wr <= 1'b1;
		for (int i = 0; i < 34; i++)
		begin
			sfr_wdata <= (i == 33) ? 8'hee : 8'h40 + 8'(i);
			@(posedge clk_sys);
		end
		sfr_wr <= 1'b0;
		chk({7'h00, tx_write_ready}, 8'h00);
		rd(SSP_ADDR_STATUS, 8'h85);
		chk({7'h00, irq}, 8'h00);
		settle(4000);
		chk(prx, 8'h60);
		rd(SSP_ADDR_STATUS, 8'h2f);
		wr(SSP_ADDR_STATUS, 8'h00);
		rd(SSP_ADDR_STATUS, 8'h28);
		rd(SSP_ADDR_RXBUF, 8'h69);
		// Slave mode: the bench acts as the external master with an 800 ns serial clock.
		master_mode <= 1'b0;
		wr(SSP_ADDR_TXBUF, 8'ha5);
		tb_ss_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd(SSP_ADDR_STATUS, 8'h82);
		chk({6'h00, miso_oe, mosi_oe}, 8'h02);
		for (int i = 7; i >= 0; i--)
		begin
			tb_mosi <= sbyte[i];
			repeat (4) @(posedge clk_sys);
			tb_sclk <= 1'b1;
			sgot = {sgot[6:0], miso_w};
			repeat (4) @(posedge clk_sys);
			tb_sclk <= 1'b0;
		end
		repeat (6) @(posedge clk_sys);
		tb_ss_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(SSP_ADDR_STATUS, 8'h0e);
		rd(SSP_ADDR_RXBUF, 8'h3c);
		chk(sgot, 8'ha5);
		complete_run();
	end
endmodule : ssp_status_pins_tb
